// file: rtl/cvd_cfg.svh
`ifndef CVD_CFG_SVH
`define CVD_CFG_SVH
// Function
// - Each comparator DAC outputs Vref/256 times the 8-bit code in its level register.
// - The valley detect enable bit turns comparator-3 valley detection on at 1 and off at 0.
// - The interrupt source select picks the debounced output at 0 and the valley result at 1.
// - A 6-bit delay code of zero bypasses, code k waits 2(k-1) to 2k clocks, codes 11xxxx wait 94 to 96 clocks.
// - With detection enabled, a trigger produces a blanking-end strobe after the programmed delay.
// - Non-inverted, the debounced output sampled at the strobe raises the interrupt only when it is 0.
// - Inverted, the debounced output sampled at the strobe raises the interrupt only when it is 1.
// - The offset trim is 6 bits for comparator 0 and 5 bits for comparators 1 to 5, held with a cal mode bit and reference select.
// - Debounce code 000 bypasses, higher codes need a stable output for about 4 up to 256 periods.

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CVD_DAC_BASE    12'h000
`define CVD_CTRL_BASE   12'h020
`define CVD_BLANK_CTRL  12'h040
`define CVD_IRQ_STATUS  12'h044
`define CVD_IRQ_MASK    12'h048
`define CVD_CMP_STATUS  12'h04C
`define CVD_NUM_CMP     6
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CVD_BC_EN       7
`define CVD_BC_IS       6
`define CVD_CT_EN       15
`define CVD_CT_CALM     14
`define CVD_CT_INV      11
`define CVD_IRQ_CMP3    0
`define CVD_IRQ_STROBE  1
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define CVD_RST_BYTE    8'h00
`define CVD_RST_TRIM    6'h20
`define CVD_DLY_CAP     6'h30
`endif

// file: rtl/cvd_debounce.sv
// Debounce of one comparator output, filter clock is sys_clk
module cvd_debounce (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Control
  input  wire logic [2:0] debounce_time_select,
  // Data
  input  wire logic       raw_in,
  output logic            filt_out
);
  logic [8:0] cnt_reg;
  logic [8:0] limit;

  // Stable count limit
  // Shift amount is four bits wide: code 7 needs a shift of 8
  assign limit = (debounce_time_select == 3'h0) ? 9'h000
                                                : 9'((9'h001 << ({1'b0, debounce_time_select} + 4'h1)) - 9'h001);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_reg  <= 9'h000;
      filt_out <= 1'b0;
    end else if (debounce_time_select == 3'h0) begin
      cnt_reg  <= 9'h000;
      filt_out <= raw_in;
    end else if (raw_in == filt_out) begin
      cnt_reg <= 9'h000;
    end else if (cnt_reg >= limit) begin
      cnt_reg  <= 9'h000;
      filt_out <= raw_in;
    end else begin
      cnt_reg <= cnt_reg + 9'h001;
    end
  end

  // code zero passes the input straight through
  chk_db_bypass: assert property (@(posedge sys_clk) disable iff (reset)
    debounce_time_select == 3'h0 |=> filt_out == $past(raw_in)) else $error("debounce bypass wrong");
endmodule // cvd_debounce

// file: rtl/cvd_pkg.sv
package cvd_pkg;
  typedef enum logic [2:0] {
    CVD_IDLE  = 3'b001,
    CVD_COUNT = 3'b010,
    CVD_DONE  = 3'b100
  } cvd_state_t;
endpackage

// file: rtl/cvd_top.sv
// The APB slave port and the register addresses were left to the implementer.
`include "cvd_cfg.svh"

// Comparator bank control with comparator-3 valley detector
module cvd_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog side
  input  wire logic [5:0]  cmp_raw,
  input  wire logic [5:0]  cal_output_status,
  input  wire logic        valley_trigger_source,
  output logic      [47:0] dac_code,
  output logic      [5:0]  comparator_enable,
  output logic      [5:0]  offset_cal_mode,
  output logic      [5:0]  cmp_output_invert,
  output logic      [11:0] hysteresis_window_select,
  output logic      [1:0]  cmp0_cal_reference_select,
  output logic      [4:0]  cal_reference_select,
  output logic      [30:0] offset_trim_value,
  // Events
  output logic             blanking_end_strobe,
  output logic             cmp3_interrupt,
  output logic             irq
);
  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [5:0] raw_m_reg, raw_s_reg, cal_m_reg, cal_s_reg;
  logic       trg_m_reg, trg_s_reg, trg_d_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      raw_m_reg <= 6'h00;
      raw_s_reg <= 6'h00;
      cal_m_reg <= 6'h00;
      cal_s_reg <= 6'h00;
      trg_m_reg <= 1'b0;
      trg_s_reg <= 1'b0;
      trg_d_reg <= 1'b0;
    end else begin
      raw_m_reg <= cmp_raw;
      raw_s_reg <= raw_m_reg;
      cal_m_reg <= cal_output_status;
      cal_s_reg <= cal_m_reg;
      trg_m_reg <= valley_trigger_source;
      trg_s_reg <= trg_m_reg;
      trg_d_reg <= trg_s_reg;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  dac_reg [6];
  logic [15:0] ctrl_reg [6];
  logic [7:0]  blank_ctrl_reg;
  logic [1:0]  irq_status_reg, irq_mask_reg;
  logic        wr_en;
  logic [1:0]  irq_set;

  assign wr_en = psel && penable && pwrite && pready;

  // Control word layout: [15] enable [14] cal mode [13:12] ref select [11] invert
  // [10:9] hysteresis [8:6] debounce [5:0] trim
  function automatic logic [15:0] ctrl_mask(input int idx);
    ctrl_mask = (idx == 0) ? 16'hFFFF : 16'hDFDF;
  endfunction

  function automatic logic in_range(input logic [11:0] a, input logic [11:0] base);
    in_range = (a >= base) && (a < base + 12'h018) && (a[1:0] == 2'h0);
  endfunction

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < `CVD_NUM_CMP; i++) begin
        dac_reg[i]  <= `CVD_RST_BYTE;
        ctrl_reg[i] <= {10'h000, `CVD_RST_TRIM} & ctrl_mask(i);
      end
      blank_ctrl_reg <= `CVD_RST_BYTE;
      irq_mask_reg   <= 2'h0;
    end else if (wr_en) begin
      for (int i = 0; i < `CVD_NUM_CMP; i++) begin
        if (paddr == `CVD_DAC_BASE + 12'(4 * i))
          dac_reg[i] <= pwdata[7:0];
        if (paddr == `CVD_CTRL_BASE + 12'(4 * i))
          ctrl_reg[i] <= pwdata[15:0] & ctrl_mask(i);
      end
      if (paddr == `CVD_BLANK_CTRL)
        blank_ctrl_reg <= pwdata[7:0];
      if (paddr == `CVD_IRQ_MASK)
        irq_mask_reg <= pwdata[1:0];
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge sys_clk) begin
    if (reset)
      irq_status_reg <= 2'h0;
    else if (wr_en && paddr == `CVD_IRQ_STATUS)
      irq_status_reg <= (irq_status_reg & ~pwdata[1:0]) | irq_set;
    else
      irq_status_reg <= irq_status_reg | irq_set;
  end

  // ----------------------------------------
  // APB read and answer
  // ----------------------------------------
  logic [5:0] db_out;
  logic [31:0] rd_mux;
  logic        hit;

  always_comb begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    if (in_range(paddr, `CVD_DAC_BASE))
      rd_mux = {24'h000000, dac_reg[3'(paddr[4:2])]};
    else if (in_range(paddr, `CVD_CTRL_BASE))
      rd_mux = {16'h0000, ctrl_reg[3'(paddr[4:2])]};
    else if (paddr == `CVD_BLANK_CTRL)
      rd_mux = {24'h000000, blank_ctrl_reg};
    else if (paddr == `CVD_IRQ_STATUS)
      rd_mux = {30'h0, irq_status_reg};
    else if (paddr == `CVD_IRQ_MASK)
      rd_mux = {30'h0, irq_mask_reg};
    else if (paddr == `CVD_CMP_STATUS)
      rd_mux = {18'h0, cal_s_reg, 2'h0, db_out};
    else
      hit = 1'b0;
  end

  // One wait state: ready in the second access-phase cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (psel && penable && !pready)
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // ----------------------------------------
  // Debounce
  // ----------------------------------------
  for (genvar g = 0; g < `CVD_NUM_CMP; g++) begin : g_db
    cvd_debounce u_db (
      .sys_clk              (sys_clk),
      .reset                (reset),
      .debounce_time_select (ctrl_reg[g][8:6]),
      .raw_in               (raw_s_reg[g]),
      .filt_out             (db_out[g])
    );
  end

  // ----------------------------------------
  // Valley detector
  // ----------------------------------------
  cvd_pkg::cvd_state_t state_reg;
  logic [6:0] dly_cnt_reg;
  logic [6:0] dly_target;
  logic       valley_detect_enable, cmp3_irq_source_select;
  logic [5:0] blanking_delay_select;
  logic       trig_edge, cmp3_debounced_output, valley_detect_result, invert3;
  logic       cmp3_prev_reg;

  assign valley_detect_enable   = blank_ctrl_reg[`CVD_BC_EN];
  assign cmp3_irq_source_select = blank_ctrl_reg[`CVD_BC_IS];
  assign blanking_delay_select  = blank_ctrl_reg[5:0];
  assign cmp3_debounced_output  = db_out[3] ^ ctrl_reg[3][`CVD_CT_INV];
  assign invert3                = ctrl_reg[3][`CVD_CT_INV];
  assign trig_edge = trg_s_reg && !trg_d_reg;

  function automatic logic [6:0] dly_of(input logic [5:0] code);
    dly_of = (code >= `CVD_DLY_CAP) ? 7'd95 : 7'({code, 1'b0} - 7'd1);
  endfunction
  assign dly_target = dly_of(blanking_delay_select);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg   <= cvd_pkg::CVD_IDLE;
      dly_cnt_reg <= 7'h00;
    end else if (!valley_detect_enable) begin
      state_reg   <= cvd_pkg::CVD_IDLE;
      dly_cnt_reg <= 7'h00;
    end else if (trig_edge) begin
      state_reg   <= (blanking_delay_select == 6'h00) ? cvd_pkg::CVD_DONE : cvd_pkg::CVD_COUNT;
      dly_cnt_reg <= 7'h00;
    end else begin
      case (state_reg)
        cvd_pkg::CVD_COUNT: begin
          dly_cnt_reg <= dly_cnt_reg + 7'h01;
          if (dly_cnt_reg + 7'h01 >= dly_target)
            state_reg <= cvd_pkg::CVD_DONE;
        end
        cvd_pkg::CVD_DONE:  state_reg <= cvd_pkg::CVD_IDLE;
        default:            state_reg <= cvd_pkg::CVD_IDLE;
      endcase
    end
  end

  // Sample at strobe, want 0 if non-inverted, 1 if inverted
  assign valley_detect_result = (state_reg == cvd_pkg::CVD_DONE) && (db_out[3] == invert3);

  // ----------------------------------------
  // Interrupt sources
  // ----------------------------------------
  logic cmp3_event;
  assign cmp3_event = cmp3_irq_source_select ? valley_detect_result
                                             : (cmp3_debounced_output && !cmp3_prev_reg);
  assign irq_set = {state_reg == cvd_pkg::CVD_DONE, cmp3_event};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmp3_prev_reg       <= 1'b0;
      blanking_end_strobe <= 1'b0;
      cmp3_interrupt      <= 1'b0;
      irq                 <= 1'b0;
    end else begin
      cmp3_prev_reg       <= cmp3_debounced_output;
      blanking_end_strobe <= (state_reg == cvd_pkg::CVD_DONE);
      cmp3_interrupt      <= cmp3_event;
      irq                 <= |((irq_status_reg | irq_set) & irq_mask_reg);
    end
  end

  // ----------------------------------------
  // Analog control outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dac_code                  <= 48'h0;
      comparator_enable         <= 6'h00;
      offset_cal_mode           <= 6'h00;
      cmp_output_invert         <= 6'h00;
      hysteresis_window_select  <= 12'h000;
      cmp0_cal_reference_select <= 2'h0;
      cal_reference_select      <= 5'h00;
      offset_trim_value         <= 31'h0;
    end else begin
      for (int i = 0; i < `CVD_NUM_CMP; i++) begin
        dac_code[8*i +: 8]               <= dac_reg[i];
        comparator_enable[i]             <= ctrl_reg[i][`CVD_CT_EN];
        offset_cal_mode[i]               <= ctrl_reg[i][`CVD_CT_CALM];
        cmp_output_invert[i]             <= ctrl_reg[i][`CVD_CT_INV];
        hysteresis_window_select[2*i +: 2] <= ctrl_reg[i][10:9];
      end
      cmp0_cal_reference_select <= ctrl_reg[0][13:12];
      offset_trim_value[5:0]    <= ctrl_reg[0][5:0];
      for (int i = 1; i < `CVD_NUM_CMP; i++) begin
        cal_reference_select[i-1]         <= ctrl_reg[i][12];
        offset_trim_value[6+5*(i-1) +: 5] <= ctrl_reg[i][4:0];
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // one-cycle strobe
  chk_strobe_single: assert property (@(posedge sys_clk) disable iff (reset)
    blanking_end_strobe |=> !blanking_end_strobe) else $error("strobe longer than one cycle");
  chk_disable_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    !valley_detect_enable && !$past(valley_detect_enable) |=> !blanking_end_strobe) else $error("strobe while off");
  chk_bypass_delay: assert property (@(posedge sys_clk) disable iff (reset)
    trig_edge && valley_detect_enable && blanking_delay_select == 6'h00 |-> ##2 blanking_end_strobe)
    else $error("bypass delay wrong");
  chk_strobe_bound: assert property (@(posedge sys_clk) disable iff (reset)
    trig_edge && valley_detect_enable && blanking_delay_select == 6'h3F
    |-> ##[90:100] blanking_end_strobe) else $error("strobe not within bound");
  chk_noninv_zero: assert property (@(posedge sys_clk) disable iff (reset)
    valley_detect_result && !invert3 |-> !db_out[3]) else $error("valley on high sample");
  chk_inv_one: assert property (@(posedge sys_clk) disable iff (reset)
    valley_detect_result && invert3 |-> db_out[3]) else $error("valley on low sample");
  chk_irq_source: assert property (@(posedge sys_clk) disable iff (reset)
    cmp3_irq_source_select && !valley_detect_result |=> !cmp3_interrupt) else $error("wrong irq source");
  chk_trig_edge: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg == cvd_pkg::CVD_COUNT && trg_d_reg && valley_detect_enable
    |=> dly_cnt_reg == $past(dly_cnt_reg) + 7'h01) else $error("held trigger restarted");
  chk_trim_width: assert property (@(posedge sys_clk) disable iff (reset)
    !ctrl_reg[1][5] && !ctrl_reg[5][5] && !ctrl_reg[1][13]) else $error("trim too wide");

  chk_restart: assert property (@(posedge sys_clk) disable iff (reset)
    trig_edge && valley_detect_enable && blanking_delay_select != 6'h00
    |=> state_reg == cvd_pkg::CVD_COUNT && dly_cnt_reg == 7'h00) else $error("blanking count not restarted");
  // strobe leaves a status bit; a clear in the same cycle must lose
  chk_strobe_status: assert property (@(posedge sys_clk) disable iff (reset)
    blanking_end_strobe |-> irq_status_reg[`CVD_IRQ_STROBE]) else $error("strobe status lost");
  chk_cmp3_status: assert property (@(posedge sys_clk) disable iff (reset)
    cmp3_interrupt |-> irq_status_reg[`CVD_IRQ_CMP3]) else $error("interrupt status lost");
  // enabled pending status drives the line
  chk_irq_follows: assert property (@(posedge sys_clk) disable iff (reset)
    (|(irq_status_reg & irq_mask_reg)) |=> irq) else $error("irq line low while pending");
  // control write lands at the ready edge
  chk_ctrl_write: assert property (@(posedge sys_clk) disable iff (reset)
    wr_en && paddr == `CVD_BLANK_CTRL
    |=> blank_ctrl_reg == $past(pwdata[7:0])) else $error("control write lost");

  cov_valley_hit:  cover property (@(posedge sys_clk) valley_detect_result);
  cov_strobe:      cover property (@(posedge sys_clk) blanking_end_strobe);
  cov_irq:         cover property (@(posedge sys_clk) irq);
  cov_bypass:      cover property (@(posedge sys_clk) trig_edge && blanking_delay_select == 6'h00 ##2 blanking_end_strobe);
  cov_src0_event:  cover property (@(posedge sys_clk) !cmp3_irq_source_select && cmp3_event);
endmodule // cvd_top

// file: sim/cvd_analog_model.sv
// ----------------------------------------
// Analog side stand-in
// ----------------------------------------
module cvd_analog_model (
  // Bench controls
  input  wire logic [5:0]  cmp_level,
  input  wire logic        trig_req,
  input  wire logic [5:0]  cal_thresh,
  // Device side
  input  wire logic [30:0] offset_trim_value,
  output logic      [5:0]  cmp_raw,
  output logic      [5:0]  cal_output_status,
  output logic             valley_trigger_source
);
  timeunit 1ns;
  timeprecision 1ns;
  assign cmp_raw = cmp_level;
  assign valley_trigger_source = trig_req;
  // Single threshold, so the up and down sweeps toggle one code apart
  assign cal_output_status = {5'h00, offset_trim_value[5:0] >= cal_thresh};
endmodule // cvd_analog_model

// file: sim/tb.sv
`include "cvd_cfg.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] TH = 6'h14;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, strobe, c3_int, irq, trig = 1'b0;
  logic [5:0]  lvl = 6'h00, raw, calo, en, calm;
  logic [1:0]  ref0;
  logic [30:0] trim;
  logic [47:0] dac;
  logic        vts;
  logic [5:0]  inv_o;
  logic [11:0] hyst;
  logic [4:0]  cref;
  int          n_mismatch = 0;
  int          checks = 0;

  cvd_analog_model i_model (.cmp_level(lvl), .trig_req(trig), .cal_thresh(TH), .offset_trim_value(trim),
    .cmp_raw(raw), .cal_output_status(calo), .valley_trigger_source(vts));
  cvd_top i_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_raw(raw),
    .cal_output_status(calo), .valley_trigger_source(vts), .dac_code(dac), .comparator_enable(en),
    .offset_cal_mode(calm), .cmp_output_invert(inv_o), .hysteresis_window_select(hyst),
    .cmp0_cal_reference_select(ref0), .cal_reference_select(cref), .offset_trim_value(trim), .blanking_end_strobe(strobe),
    .cmp3_interrupt(c3_int), .irq(irq));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // APB master: hold the request until pready
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Counts edges from trigger to strobe; a missing strobe ends the run
  task automatic wait_strobe(output int n);
    for (n = 1; n <= 300; n++) begin
      @(posedge sys_clk);
      if (strobe === 1'b1) break;
    end
    if (n > 300) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  task automatic t_regs();
    apb(1'b0, `CVD_BLANK_CTRL, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, `CVD_DAC_BASE + 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `CVD_DAC_BASE + 12'(4 * i), 32'h0000_00F0 ^ 32'(37 * i));
      apb(1'b0, `CVD_DAC_BASE + 12'(4 * i), 32'h0);
      chk(rd, 32'h0000_00F0 ^ 32'(37 * i));
      chk(dac[8*i+:8], 8'hF0 ^ 8'(37 * i));
    end
    apb(1'b0, 12'h050, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_delay(input logic [5:0] k, input int lo, input int hi);
    int n;
    int extra;
    apb(1'b1, `CVD_BLANK_CTRL, {24'h0, 2'b11, k});
    trig <= 1'b1;
    wait_strobe(n);
    chk(n >= lo && n <= hi, 1'b1);
    @(posedge sys_clk);
    chk(strobe, 1'b0);
    extra = 0;
    repeat (120) begin
      @(posedge sys_clk);
      extra += strobe;
    end
    chk(extra, 0);
    trig <= 1'b0;
    cyc(4);
    $display("t_delay %0d done", k);
  endtask

  task automatic t_disabled();
    int cnt = 0;
    apb(1'b1, `CVD_BLANK_CTRL, 32'h0000_0041);
    trig <= 1'b1;
    repeat (40) begin
      @(posedge sys_clk);
      cnt += strobe;
    end
    chk(cnt, 0);
    trig <= 1'b0;
    cyc(4);
    $display("t_disabled done");
  endtask

  task automatic t_valley(input logic inv, input logic level);
    logic seen = 1'b0;
    apb(1'b1, `CVD_CTRL_BASE + 12'h00C, {20'h0, inv, 11'h0});
    lvl[3] <= level;
    cyc(8);
    chk(inv_o[3], inv);
    apb(1'b1, `CVD_BLANK_CTRL, 32'h0000_00C2);
    trig <= 1'b1;
    repeat (40) begin
      @(posedge sys_clk);
      seen |= c3_int;
    end
    chk(seen, inv == level);
    trig <= 1'b0;
    cyc(4);
    $display("t_valley %0d %0d done", inv, level);
  endtask

  task automatic t_src0();
    logic seen = 1'b0;
    apb(1'b1, `CVD_BLANK_CTRL, 32'h0);
    apb(1'b1, `CVD_CTRL_BASE + 12'h00C, 32'h0);
    lvl[3] <= 1'b0;
    cyc(8);
    lvl[3] <= 1'b1;
    repeat (20) begin
      @(posedge sys_clk);
      seen |= c3_int;
    end
    chk(seen, 1'b1);
    $display("t_src0 done");
  endtask

  task automatic t_irq();
    apb(1'b1, `CVD_IRQ_STATUS, 32'h3);
    apb(1'b1, `CVD_IRQ_MASK, 32'h0);
    t_valley(1'b0, 1'b0);
    apb(1'b0, `CVD_IRQ_STATUS, 32'h0);
    chk(rd, 32'h3);
    chk(irq, 1'b0);
    apb(1'b1, `CVD_IRQ_MASK, 32'h3);
    cyc(1);
    chk(irq, 1'b1);
    apb(1'b1, `CVD_IRQ_STATUS, 32'h3);
    cyc(1);
    chk(irq, 1'b0);
    apb(1'b1, `CVD_IRQ_MASK, 32'h0);
    cyc(1);
    chk(irq, 1'b0);
    apb(1'b0, `CVD_IRQ_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("t_irq done");
  endtask

  // ----------------------------------------
  // Calibration sweep as software does it
  // ----------------------------------------
  task automatic sweep(input int start, input int step, output int t);
    logic prev;
    apb(1'b1, `CVD_CTRL_BASE, 32'h0000_F000 | 32'(start));
    cyc(6);
    apb(1'b0, `CVD_CMP_STATUS, 32'h0);
    prev = rd[8];
    for (t = start + step; t >= 0 && t < 64; t += step) begin
      apb(1'b1, `CVD_CTRL_BASE, 32'h0000_F000 | 32'(t));
      cyc(6);
      apb(1'b0, `CVD_CMP_STATUS, 32'h0);
      if (rd[8] !== prev) break;
    end
  endtask

  task automatic t_cal();
    int lo;
    int hi;
    sweep(0, 1, lo);
    sweep(63, -1, hi);
    apb(1'b1, `CVD_CTRL_BASE, 32'h0000_F000 | 32'((lo + hi) / 2));
    cyc(1);
    chk(trim[5:0], TH - 6'h01);
    chk({en[0], calm[0], ref0}, 4'hF);
    apb(1'b1, `CVD_CTRL_BASE + 12'h004, 32'h0000_B63F);
    apb(1'b0, `CVD_CTRL_BASE + 12'h004, 32'h0);
    chk(rd[5:0], 6'h1F);
    chk(rd, 32'h0000_961F);
    chk(trim[10:6], 5'h1F);
    chk(cref[0], 1'b1);
    chk(hyst[3:2], 2'h3);
    $display("t_cal done");
  endtask

  // Long code must hold off a level held for 20 cycles, short code must then pass the same steady level
  task automatic t_debounce();
    apb(1'b1, `CVD_CTRL_BASE + 12'h008, 32'h0000_01C0);
    lvl[2] <= 1'b1;
    cyc(20);
    apb(1'b0, `CVD_CMP_STATUS, 32'h0);
    chk(rd[2], 1'b0);
    apb(1'b1, `CVD_CTRL_BASE + 12'h008, 32'h0000_0040);
    cyc(10);
    apb(1'b0, `CVD_CMP_STATUS, 32'h0);
    chk(rd[2], 1'b1);
    $display("t_debounce done");
  endtask

  initial begin
    cyc(16);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_delay(6'h00, 1, 6);
    t_delay(6'h01, 1, 8);
    t_delay(6'h02, 3, 10);
    t_delay(6'h2F, 93, 100);
    t_delay(6'h30, 95, 102);
    t_delay(6'h3F, 95, 102);
    t_disabled();
    t_valley(1'b0, 1'b1);
    t_valley(1'b1, 1'b1);
    t_valley(1'b1, 1'b0);
    t_src0();
    t_irq();
    t_cal();
    t_debounce();
    tally_and_finish();
  end
endmodule // tb
